// ---- design/dcc_top.sv ----
// Purpose: converter channel data and channel 1 trim registers
// Assumes: synchronous active-high reset, single 50 MHz clock
// Notes:   waitrequest drops one cycle after a request appears;
//          read data is latched at that edge, writes land one edge later;
//          the low-byte temp is shared by both channels
// Behaviour
// - Channel 1 gain trim, 8-bit read/write, resets to zero, drives output.
// - Channel 1 offset trim, 8-bit read/write, resets to zero, drives output.
// - Each channel's 12-bit value spans a high and a low byte register.
// - Right-aligned: low byte is bits 7:0, high byte low nibble bits 11:8.
// - Alignment select switches both channels to left-aligned layout.
// - Left-aligned: high is bits 11:4, low 7:4 bits 3:0, low 3:0 reserved.
// - Left-aligned, writing only high byte gives a complete value.
// - Right-aligned high byte 7:4 reads zero, read-only; software writes zero.
// - Channel 1 registers mirror channel 0 layout in both modes.
// - Alignment select is bit 0 of third control register, resets zero.
`default_nettype none
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  wire logic [DCC_ADDR_W-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    output logic      [1:0]            avs_response_out,
    output logic      [11:0]           chan0_value_out,
    output logic      [11:0]           chan1_value_out,
    output logic      [7:0]            chan1_gain_trim_out,
    output logic      [7:0]            chan1_offset_trim_out,
    output logic                       msb_align_select_out
);

    typedef struct packed {
        logic [7:0]  gain1;
        logic [7:0]  offs1;
        logic [11:0] val0;
        logic [11:0] val1;
        logic [7:0]  temp;
        logic        align;
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  resp;
    } dcc_state_t;

    dcc_state_t st_ff;
    dcc_state_t nxt_st;

    logic       req;
    logic       wr_go;
    logic       rd_go;
    logic [5:0] idx;
    logic       word_ok;
    logic       hit;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic       misaligned;
    logic       lane0_en;

    logic       sel_ctrl3;
    logic       sel_gain1;
    logic       sel_offs1;
    logic       sel_c0lo;
    logic       sel_c0hi;
    logic       sel_c1lo;
    logic       sel_c1hi;

    logic       put_ctrl3;
    logic       put_gain1;
    logic       put_offs1;
    logic       put_lo;
    logic       put_c0hi;
    logic       put_c1hi;

    logic [7:0] c0_lo_view;
    logic [7:0] c0_hi_view;
    logic [7:0] c1_lo_view;
    logic [7:0] c1_hi_view;
    logic [11:0] high_join;

    // Answer codes on the response lines
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    assign req     = avs_read_in | avs_write_in;
    assign idx     = avs_address_in[7:2];
    // Any byte offset inside a word is refused
    assign misaligned = (avs_address_in[1:0] != 2'h0);
    assign word_ok    = ~misaligned;

    // Only the low lane carries register data
    assign wbyte    = avs_writedata_in[7:0];
    assign lane0_en = avs_byteenable_in[0];

    // Writes land at the edge that ends the wait, never an edge early
    assign wr_go = avs_write_in & st_ff.ack & lane0_en;
    // Read data is latched a cycle early so it stands at that edge
    assign rd_go = avs_read_in & ~st_ff.ack;

    // A misaligned address selects nothing
    assign sel_ctrl3 = word_ok & (idx == DCC_IDX_CTRL3);
    assign sel_gain1 = word_ok & (idx == DCC_IDX_GAIN1);
    assign sel_offs1 = word_ok & (idx == DCC_IDX_OFFS1);
    assign sel_c0lo  = word_ok & (idx == DCC_IDX_C0LO);
    assign sel_c0hi  = word_ok & (idx == DCC_IDX_C0HI);
    assign sel_c1lo  = word_ok & (idx == DCC_IDX_C1LO);
    assign sel_c1hi  = word_ok & (idx == DCC_IDX_C1HI);

    // Per-register write strobes
    assign put_ctrl3 = wr_go & sel_ctrl3;
    assign put_gain1 = wr_go & sel_gain1;
    assign put_offs1 = wr_go & sel_offs1;
    assign put_lo    = wr_go & (sel_c0lo | sel_c1lo);
    assign put_c0hi  = wr_go & sel_c0hi;
    assign put_c1hi  = wr_go & sel_c1hi;

    always_comb begin
        hit = 1'b0;
        if (sel_ctrl3 || sel_gain1 || sel_offs1) begin
            hit = 1'b1;
        end

        if (sel_c0lo || sel_c0hi) begin
            hit = 1'b1;
        end

        if (sel_c1lo || sel_c1hi) begin
            hit = 1'b1;
        end
    end

    // Channel 0 low byte as read back
    always_comb begin
        if (st_ff.align) begin
            c0_lo_view = {st_ff.val0[3:0], 4'h0};
        end else begin
            c0_lo_view = st_ff.val0[7:0];
        end
    end

    // Channel 0 high byte as read back
    always_comb begin
        if (st_ff.align) begin
            c0_hi_view = st_ff.val0[11:4];
        end else begin
            c0_hi_view = {4'h0, st_ff.val0[11:8]};
        end
    end

    // Channel 1 low byte mirrors channel 0
    always_comb begin
        if (st_ff.align) begin
            c1_lo_view = {st_ff.val1[3:0], 4'h0};
        end else begin
            c1_lo_view = st_ff.val1[7:0];
        end
    end

    // Channel 1 high byte mirrors channel 0
    always_comb begin
        if (st_ff.align) begin
            c1_hi_view = st_ff.val1[11:4];
        end else begin
            c1_hi_view = {4'h0, st_ff.val1[11:8]};
        end
    end

    // Temp is write-only staging and never shows on a read
    always_comb begin
        rbyte = 8'h00;

        case (idx)
            DCC_IDX_CTRL3: begin
                rbyte = {7'h00, st_ff.align};
            end

            DCC_IDX_GAIN1: begin
                rbyte = st_ff.gain1;
            end

            DCC_IDX_OFFS1: begin
                rbyte = st_ff.offs1;
            end

            DCC_IDX_C0LO: begin
                rbyte = c0_lo_view;
            end

            DCC_IDX_C0HI: begin
                rbyte = c0_hi_view;
            end

            DCC_IDX_C1LO: begin
                rbyte = c1_lo_view;
            end

            DCC_IDX_C1HI: begin
                rbyte = c1_hi_view;
            end

            default: begin
                rbyte = 8'h00;
            end
        endcase
    end

    function automatic logic [11:0] dcc_join(
        input logic       left,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        // Reserved bits are dropped, so stray ones never reach the value
        dcc_join = 12'h000;
        if (left) begin
            dcc_join[11:4] = hi;
            dcc_join[3:0]  = lo[7:4];
        end else begin
            dcc_join[11:8] = hi[3:0];
            dcc_join[7:0]  = lo;
        end
    endfunction

    // Layout at the moment of the high write decides the join
    assign high_join = dcc_join(st_ff.align, wbyte, st_ff.temp);

    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = 1'b0;

        // One wait cycle lets decode settle before the answer
        if (req && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            if (hit) begin
                nxt_st.resp = RESP_OK;
            end else begin
                nxt_st.resp = RESP_ERR;
            end

            if (rd_go && hit) begin
                nxt_st.rdata = {24'h0, rbyte};
            end else begin
                nxt_st.rdata = 32'h0;
            end
        end

        if (put_ctrl3) begin
            nxt_st.align = wbyte[DCC_ALIGN_BIT];
        end

        if (put_gain1) begin
            nxt_st.gain1 = wbyte;
        end

        if (put_offs1) begin
            nxt_st.offs1 = wbyte;
        end

        // One temp serves both channels and outlives the transfer
        if (put_lo) begin
            nxt_st.temp = wbyte;
        end

        if (put_c0hi) begin
            nxt_st.val0 = high_join;
        end

        if (put_c1hi) begin
            nxt_st.val1 = high_join;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_ff.gain1 <= DCC_TRIM_RST;
            st_ff.offs1 <= DCC_TRIM_RST;
            st_ff.val0  <= DCC_VAL_RST;
            st_ff.val1  <= DCC_VAL_RST;
            st_ff.temp  <= DCC_TEMP_RST;
            st_ff.align <= DCC_ALIGN_RST;
            st_ff.ack   <= 1'b0;
            st_ff.rdata <= 32'h0;
            st_ff.resp  <= 2'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_waitrequest_out  = req & ~st_ff.ack;
    assign avs_readdata_out     = st_ff.rdata;
    assign avs_response_out     = st_ff.resp;
    assign chan0_value_out       = st_ff.val0;
    assign chan1_value_out       = st_ff.val1;
    assign chan1_gain_trim_out   = st_ff.gain1;
    assign chan1_offset_trim_out = st_ff.offs1;
    assign msb_align_select_out  = st_ff.align;

endmodule : dcc_top
`default_nettype wire

// ---- design/dcc_pkg.sv ----
// Purpose: constants for the converter data and trim register front end
// Assumes: Avalon-MM slave, 32-bit data, word per register
// Notes:   byte address is four times the printed register index
`default_nettype none
package dcc_pkg;
    localparam int unsigned DCC_ADDR_W   = 8;
    // Printed register indices
    localparam logic [5:0] DCC_IDX_CTRL3 = 6'h02;
    localparam logic [5:0] DCC_IDX_GAIN1 = 6'h0a;
    localparam logic [5:0] DCC_IDX_OFFS1 = 6'h0b;
    localparam logic [5:0] DCC_IDX_C0LO  = 6'h18;
    localparam logic [5:0] DCC_IDX_C0HI  = 6'h19;
    localparam logic [5:0] DCC_IDX_C1LO  = 6'h1a;
    localparam logic [5:0] DCC_IDX_C1HI  = 6'h1b;
    // Field positions and reset values
    localparam int unsigned DCC_ALIGN_BIT = 0;
    localparam logic [7:0]  DCC_TRIM_RST  = 8'h00;
    localparam logic [11:0] DCC_VAL_RST   = 12'h000;
    localparam logic [7:0]  DCC_TEMP_RST  = 8'h00;
    localparam logic        DCC_ALIGN_RST = 1'b0;
endpackage : dcc_pkg
`default_nettype wire

// ---- dv/dcc_top_assertions.sv ----
// Purpose: port checks for dcc_top
// Assumes: one clock, sync active-high reset
// Notes:   bound to the design below
`default_nettype none
module dcc_top_chk import dcc_pkg::*; (
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic        avs_waitrequest_out,
    input wire logic [1:0]  avs_response_out,
    input wire logic [11:0] chan1_value_out,
    input wire logic [7:0]  chan1_gain_trim_out,
    input wire logic [7:0]  chan1_offset_trim_out,
    input wire logic        msb_align_select_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic wr;
    assign wr = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
    sequence req_s;
        (avs_read_in | avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence put_s(logic [7:0] a);
        wr && avs_address_in == a;
    endsequence
    ack_next_a: assert property (req_s |=> !avs_waitrequest_out)
        else $error("no ack");
    gain_load_a: assert property (put_s(8'h28) |=>
        chan1_gain_trim_out == $past(avs_writedata_in[7:0])) else $error("g");
    offs_load_a: assert property (put_s(8'h2c) |=>
        chan1_offset_trim_out == $past(avs_writedata_in[7:0])) else $error("o");
    gain_keep_a: assert property (!(wr && avs_address_in == 8'h28) |=>
        $stable(chan1_gain_trim_out)) else $error("g moved");
    align_load_a: assert property (put_s(8'h08) |=>
        msb_align_select_out == $past(avs_writedata_in[0])) else $error("al");
    high_right_a: assert property (put_s(8'h6c) ##0 !msb_align_select_out
        |=> chan1_value_out[11:8] == $past(avs_writedata_in[3:0]))
        else $error("right");
    high_left_a: assert property (put_s(8'h6c) ##0 msb_align_select_out
        |=> chan1_value_out[11:4] == $past(avs_writedata_in[7:0]))
        else $error("left");
    bad_addr_a: assert property ((avs_read_in | avs_write_in) &&
        !avs_waitrequest_out && avs_address_in[1:0] != 2'h0 |->
        avs_response_out == 2'h2) else $error("resp");
endmodule // dcc_top_chk
bind dcc_top dcc_top_chk dcc_top_chk_i (.*);
`default_nettype wire

// ---- dv/dcc_top_tb.sv ----
// Purpose: self-checking bench for dcc_top
// Assumes: Avalon-MM master, 50 MHz clock
// Notes:   idle cycle between accesses keeps drivers race free
`default_nettype none
module dcc_top_tb import dcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wt, al;
    logic [7:0]  adr = 8'h00, g1, o1;
    logic [31:0] wd = 32'h0, rdq, q;
    logic [3:0]  be = 4'h1;
    logic [1:0]  rsp, rq;
    logic [11:0] v0, v1;
    int          n_errors = 0, n_checks = 0, cyc = 0;
    dcc_top dcc_top_i (.core_clk_in(clk), .rst_in(rst), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdq),
        .avs_waitrequest_out(wt), .avs_response_out(rsp),
        .chan0_value_out(v0), .chan1_value_out(v1),
        .chan1_gain_trim_out(g1), .chan1_offset_trim_out(o1),
        .msb_align_select_out(al));
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Waitrequest is sampled at the rising edge; the answer is taken there
    task automatic acc(input logic w, input logic [7:0] a, d);
        {adr, wd, wr, rd} <= {a, 24'h0, d, w, !w};
        do @(posedge clk); while (wt !== 1'b0);
        {q, rq} = {rdq, rsp};
        {wr, rd} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            complete_run;
        end
    end
    task automatic t_reset;
        logic [7:0] ra [7] = '{8'h28, 8'h2c, 8'h08, 8'h60, 8'h64, 8'h68, 8'h6c};
        foreach (ra[i]) begin
            acc(0, ra[i], 0);
            chk(q, 0);
        end
        chk({v0, v1, g1}, 0);
        chk({o1, al}, 0);
        $display("reset done");
    endtask
    task automatic t_trim;
        acc(1, 8'h28, 8'ha5);
        acc(1, 8'h2c, 8'h5a);
        acc(0, 8'h28, 0);
        chk(q, 32'ha5);
        acc(0, 8'h2c, 0);
        chk(q, 32'h5a);
        be <= 4'h0;
        acc(1, 8'h28, 8'h11);
        be <= 4'h1;
        chk({g1, o1}, 16'ha55a);
        acc(1, 8'h29, 8'hff);
        chk({rq, g1}, 10'h2a5);
        $display("trim done");
    endtask
    task automatic t_right;
        acc(1, 8'h60, 8'h34);
        acc(1, 8'h64, 8'h02);
        chk(v0, 12'h234);
        acc(0, 8'h64, 0);
        chk(q, 32'h02);
        acc(0, 8'h60, 0);
        chk(q, 32'h34);
        acc(1, 8'h6c, 8'h07);
        chk(v1, 12'h734);
        $display("right done");
    endtask
    task automatic t_left;
        acc(1, 8'h08, 8'h01);
        chk({al, v0}, 13'h1234);
        acc(0, 8'h64, 0);
        chk(q, 32'h23);
        acc(1, 8'h68, 8'hb0);
        acc(1, 8'h6c, 8'hc9);
        chk(v1, 12'hc9b);
        acc(0, 8'h68, 0);
        chk(q, 32'hb0);
        acc(1, 8'h60, 8'h00);
        acc(1, 8'h64, 8'h80);
        chk(v0, 12'h800);
        acc(1, 8'h64, 8'h81);
        chk(v0, 12'h810);
        $display("left done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_trim;
        t_right;
        t_left;
        complete_run;
    end
endmodule // dcc_top_tb
`default_nettype wire
